/* File: hw/ddct_pkg.sv */
package ddct_pkg;

    // Register byte offsets, one aligned 32-bit word each.
    localparam logic [11:0] OFF_DIRECT_RELOAD = 12'h000;
    localparam logic [11:0] OFF_CURRENT_COUNT = 12'h004;
    localparam logic [11:0] OFF_TIMER_CONTROL = 12'h008;
    localparam logic [11:0] OFF_INTERRUPT_CLEAR = 12'h00c;
    localparam logic [11:0] OFF_RAW_STATUS = 12'h010;
    localparam logic [11:0] OFF_MASKED_STATUS = 12'h014;
    localparam logic [11:0] OFF_BACKGROUND_RELOAD = 12'h018;

    // Field positions inside timer_control.
    localparam int CTRL_RUN_ENABLE_BIT = 7;
    localparam int CTRL_PERIODIC_BIT = 6;
    localparam int CTRL_IRQ_ENABLE_BIT = 5;
    localparam int CTRL_PRESCALE_LSB = 2;
    localparam int CTRL_WIDTH_BIT = 1;
    localparam int CTRL_FIELD_W = 8;

    // Reset values and the free running wrap values.
    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [31:0] RELOAD_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_RESET = 32'hffffffff;
    localparam logic [15:0] WRAP_16 = 16'hffff;
    localparam logic [31:0] WRAP_32 = 32'hffffffff;

    // Prescale codes and the stage counts they select.
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV16 = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam int PRE_STAGES_16 = 4;
    localparam int PRE_STAGES_256 = 8;

    // Layout of timer_control, bit 7 first.
    typedef struct packed {
        logic timer_run_enable;
        logic periodic_select;
        logic irq_mask_enable;
        logic keep4;
        logic [1:0] prescale_select;
        logic counter_width_select;
        logic keep0;
    } ddct_ctrl_t;

    // Bus responder phases.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESPOND = 2'b10
    } ddct_bus_state_t;

endpackage

/* File: hw/ddct_prescaler.sv */
module ddct_prescaler #(
    parameter int STAGES = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Control.
    input wire logic advance_in,
    input wire logic restart_in,
    input wire logic [1:0] select_in,
    // Divided tick.
    output logic tick_out
);

    logic [STAGES-1:0] stage_reg;
    logic [8:0] since_reg;
    logic [1:0] select_prev_reg;

    if (STAGES < ddct_pkg::PRE_STAGES_256) begin : g_check
        $error("ddct_prescaler needs at least eight stages");
    end

    // Code 11 has no defined ratio; it is served as the longest divide so the counter never races.
    always_comb begin
        tick_out = 1'b0;
        if (advance_in) begin
            case (select_in)
                ddct_pkg::PRE_DIV1: tick_out = 1'b1; // [RQ1]
                ddct_pkg::PRE_DIV16: tick_out = &stage_reg[ddct_pkg::PRE_STAGES_16-1:0]; // [RQ1]
                default: tick_out = &stage_reg[ddct_pkg::PRE_STAGES_256-1:0]; // [RQ1]
            endcase
        end
    end

    // Stages move only on qualified, enabled edges.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage_reg <= '0;
        end else if (restart_in) begin
            stage_reg <= '0;
        end else if (advance_in) begin
            stage_reg <= stage_reg + 1'b1; // [RQ18]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_reg <= 9'h000;
            select_prev_reg <= 2'h0;
        end else begin
            select_prev_reg <= select_in;
            if (restart_in || tick_out) begin
                since_reg <= 9'h000;
            end else if (advance_in) begin
                since_reg <= since_reg + 9'h001;
            end
        end
    end

    a_div16_spacing: assert property (@(posedge clk_in) disable iff (rst_in)
        tick_out && select_in == ddct_pkg::PRE_DIV16 && select_prev_reg == select_in
        && since_reg != 9'h000 |-> since_reg == 9'h00f) // [RQ1]
        else $error("divide by 16 tick at wrong spacing");

    a_div256_spacing: assert property (@(posedge clk_in) disable iff (rst_in)
        tick_out && select_in == ddct_pkg::PRE_DIV256 && select_prev_reg == select_in
        && since_reg != 9'h000 |-> since_reg == 9'h0ff) // [RQ1]
        else $error("divide by 256 tick at wrong spacing");

endmodule

/* File: hw/ddct_timer.sv */
// Overview of operation
// (RQ1) Prescale code 00 divides by 1, 01 by 16, 10 by 256.
// (RQ2) Software never writes prescale code 11.
// (RQ3) Width bit clear counts 16 bits, set counts 32 bits.
// (RQ4) Software leaves control bit 4 alone and ignores it on read.
// (RQ5) Software disables the timer before changing mode, width or prescale.
// (RQ6) Any write to interrupt_clear drops the pending interrupt; a zero event in the same cycle keeps it set instead.
// (RQ7) Raw status bit 0 shows the interrupt regardless of its enable.
// (RQ8) Masked status bit 0 is raw AND enable, and drives the irq pin.
// (RQ9) Status bits 31 to 1 are reserved and carry nothing.
// (RQ10) Background reload holds 32 bits, reloaded at zero in periodic mode.
// (RQ11) Background reload writes do not restart the running count.
// (RQ12) Background reload reads return the same as direct reload reads.
// (RQ13) Control bit 7 runs the timer, cleared after reset.
// (RQ14) Control bit 6 selects periodic reload, free running after reset.
// (RQ15) Control bit 5 enables the interrupt, set after reset.
// (RQ16) A direct reload write replaces the count at the next qualified edge.
// (RQ17) Reaching zero sets the raw interrupt until interrupt_clear is written.
// (RQ18) Prescaler moves on qualified edges only; count drops once per tick.
//
// Register access over APB and the register addresses were left to the implementer.
module ddct_timer (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Counting qualifier.
    input wire logic count_clock_qualifier_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Interrupt.
    output logic timer_irq_out
);

    ddct_pkg::ddct_bus_state_t bus_state_reg;
    ddct_pkg::ddct_ctrl_t ctrl_reg;
    ddct_pkg::ddct_ctrl_t ctrl_next;
    logic [31:0] reload_reg;
    logic [31:0] pend_value_reg;
    logic pend_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic raw_reg;
    logic raw_next;
    logic bus_done;
    logic bus_start;
    logic wr_load;
    logic wr_bg;
    logic wr_ctrl;
    logic wr_clear;
    logic apply_load;
    logic tick;
    logic zero_event;
    logic [31:0] count_view;
    logic [31:0] pend_view;
    logic [31:0] read_value;
    logic read_hit;

    // Bus access: one wait state, write and read completion at the pready edge.
    assign bus_done = psel_in && penable_in && pready_out;
    assign bus_start = psel_in && penable_in && !pready_out;
    assign wr_load = bus_done && pwrite_in && paddr_in == ddct_pkg::OFF_DIRECT_RELOAD;
    assign wr_bg = bus_done && pwrite_in && paddr_in == ddct_pkg::OFF_BACKGROUND_RELOAD;
    assign wr_ctrl = bus_done && pwrite_in && paddr_in == ddct_pkg::OFF_TIMER_CONTROL;
    assign wr_clear = bus_done && pwrite_in && paddr_in == ddct_pkg::OFF_INTERRUPT_CLEAR; // [RQ6]

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_state_reg <= ddct_pkg::BUS_IDLE;
            pready_out <= 1'b0;
        end else begin
            case (bus_state_reg)
                ddct_pkg::BUS_IDLE: begin
                    if (bus_start) begin
                        bus_state_reg <= ddct_pkg::BUS_RESPOND;
                        pready_out <= 1'b1;
                    end
                end
                ddct_pkg::BUS_RESPOND: begin
                    bus_state_reg <= ddct_pkg::BUS_IDLE;
                    pready_out <= 1'b0;
                end
                default: begin
                    bus_state_reg <= ddct_pkg::BUS_IDLE;
                    pready_out <= 1'b0;
                end
            endcase
        end
    end

    // Count as seen by software: a pending direct load shows at once.
    assign count_view = pend_reg ? pend_value_reg : count_reg;

    always_comb begin
        read_value = 32'h00000000;
        read_hit = 1'b1;
        case (paddr_in)
            ddct_pkg::OFF_DIRECT_RELOAD: read_value = reload_reg;
            ddct_pkg::OFF_BACKGROUND_RELOAD: read_value = reload_reg; // [RQ12]
            ddct_pkg::OFF_CURRENT_COUNT: read_value = count_view;
            ddct_pkg::OFF_TIMER_CONTROL: read_value = {24'h000000, ctrl_reg};
            ddct_pkg::OFF_INTERRUPT_CLEAR: read_value = 32'h00000000;
            ddct_pkg::OFF_RAW_STATUS: read_value = {31'h00000000, raw_reg}; // [RQ7] [RQ9]
            ddct_pkg::OFF_MASKED_STATUS: read_value = {31'h00000000, timer_irq_out}; // [RQ8] [RQ9]
            default: read_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else if (bus_start) begin
            prdata_out <= pwrite_in ? 32'h00000000 : read_value;
            pslverr_out <= !read_hit;
        end else if (bus_done) begin
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
        end
    end

    // Control: bit 4 and bit 0 are stored as written and have no effect.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata_in[ddct_pkg::CTRL_FIELD_W-1:0]; // [RQ13] [RQ14] [RQ15]
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= ddct_pkg::CTRL_RESET; // [RQ13] [RQ14] [RQ15]
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Both reload addresses share one value; only the direct one arms a restart.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reload_reg <= ddct_pkg::RELOAD_RESET;
        end else if (wr_load || wr_bg) begin
            reload_reg <= pwdata_in; // [RQ10] [RQ11]
        end
    end

    // A load written in the same cycle as a qualified edge waits for the next one.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pend_reg <= 1'b0;
            pend_value_reg <= ddct_pkg::RELOAD_RESET;
        end else if (wr_load) begin
            pend_reg <= 1'b1;
            pend_value_reg <= pwdata_in;
        end else if (apply_load) begin
            pend_reg <= 1'b0;
        end
    end

    assign apply_load = count_clock_qualifier_in && pend_reg; // [RQ16]

    ddct_prescaler #(
        .STAGES(ddct_pkg::PRE_STAGES_256)
    ) u_prescaler (
        .clk_in(core_clk_in),
        .rst_in(sys_rst_in),
        .advance_in(count_clock_qualifier_in && ctrl_reg.timer_run_enable && !pend_reg), // [RQ18] [RQ13]
        .restart_in(apply_load || !ctrl_reg.timer_run_enable),
        .select_in(ctrl_reg.prescale_select),
        .tick_out(tick)
    );

    assign pend_view = ctrl_reg.counter_width_select ? pend_value_reg : {16'h0000, pend_value_reg[15:0]};

    // In 16-bit mode a tick leaves the upper half as it was; a direct load still writes all 32 bits.
    always_comb begin
        count_next = count_reg;
        zero_event = 1'b0;
        if (apply_load) begin
            count_next = pend_value_reg; // [RQ16]
            zero_event = pend_view == 32'h00000000;
        end else if (tick) begin
            if (ctrl_reg.counter_width_select) begin
                if (count_reg == 32'h00000000) begin
                    count_next = ctrl_reg.periodic_select ? reload_reg : ddct_pkg::WRAP_32; // [RQ10] [RQ14]
                end else begin
                    count_next = count_reg - 32'h00000001; // [RQ3] [RQ18]
                end
                zero_event = count_next == 32'h00000000; // [RQ17]
            end else begin
                if (count_reg[15:0] == 16'h0000) begin
                    count_next[15:0] = ctrl_reg.periodic_select ? reload_reg[15:0] : ddct_pkg::WRAP_16; // [RQ14]
                end else begin
                    count_next[15:0] = count_reg[15:0] - 16'h0001; // [RQ3] [RQ18]
                end
                zero_event = count_next[15:0] == 16'h0000; // [RQ17]
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_reg <= ddct_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // A new zero event in the clearing cycle keeps the flag set.
    always_comb begin
        raw_next = raw_reg;
        if (zero_event) begin
            raw_next = 1'b1; // [RQ17]
        end else if (wr_clear) begin
            raw_next = 1'b0; // [RQ6]
        end
    end

    // The pin is built from next values so it always equals the masked status.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            raw_reg <= 1'b0;
            timer_irq_out <= 1'b0;
        end else begin
            raw_reg <= raw_next;
            timer_irq_out <= raw_next && ctrl_next.irq_mask_enable; // [RQ8]
        end
    end

    a_irq_equals_mis: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        timer_irq_out == (raw_reg && ctrl_reg.irq_mask_enable)) // [RQ8]
        else $error("irq pin differs from masked status");

    a_clear_drops_raw: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        wr_clear && !zero_event |=> !raw_reg && !timer_irq_out) // [RQ6]
        else $error("interrupt clear did not drop the interrupt");

    a_zero_sets_raw: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        zero_event |=> raw_reg ##1 (raw_reg || $past(wr_clear))) // [RQ17]
        else $error("zero event did not set or hold the raw interrupt");

    a_disabled_holds: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !ctrl_reg.timer_run_enable && !apply_load |=> count_reg == $past(count_reg)) // [RQ13]
        else $error("count moved while disabled");

    a_load_applies: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        apply_load |=> count_reg == $past(pend_value_reg) && (!pend_reg || $past(wr_load))) // [RQ16]
        else $error("direct reload not applied at qualified edge");

    a_bg_no_restart: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        wr_bg && !pend_reg && !tick |=> count_reg == $past(count_reg)) // [RQ11]
        else $error("background reload restarted the count");

    a_upper_kept: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        tick && !ctrl_reg.counter_width_select |=> count_reg[31:16] == $past(count_reg[31:16])) // [RQ3]
        else $error("16-bit mode touched the upper half");

    a_periodic_reload: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        tick && ctrl_reg.counter_width_select && ctrl_reg.periodic_select && count_reg == 32'h00000000
        |=> count_reg == $past(reload_reg)) // [RQ10] [RQ14]
        else $error("periodic mode did not reload at zero");

    a_free_wrap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        tick && ctrl_reg.counter_width_select && !ctrl_reg.periodic_select && count_reg == 32'h00000000
        |=> count_reg == 32'hffffffff) // [RQ14]
        else $error("free running mode did not wrap");

    a_tick_qualified: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        count_reg != $past(count_reg) |-> $past(apply_load || (tick && count_clock_qualifier_in))) // [RQ18]
        else $error("count changed without a qualified tick");

    a_raw_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        bus_start && !pwrite_in && paddr_in == ddct_pkg::OFF_RAW_STATUS
        |=> prdata_out == {31'h00000000, $past(raw_reg)} && pready_out) // [RQ7] [RQ9]
        else $error("raw status read returned wrong data");

    a_bg_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        bus_start && !pwrite_in && paddr_in == ddct_pkg::OFF_BACKGROUND_RELOAD
        |=> prdata_out == $past(reload_reg)) // [RQ12]
        else $error("background reload read differs from reload value");

    a_reload_low_half: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        tick && !ctrl_reg.counter_width_select && ctrl_reg.periodic_select && count_reg[15:0] == 16'h0000
        |=> count_reg[15:0] == $past(reload_reg[15:0])) // [RQ10] [RQ14]
        else $error("16-bit periodic mode did not reload at zero");

    a_load_zero_irq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        apply_load && pend_view == 32'h00000000 |=> raw_reg) // [RQ16] [RQ17]
        else $error("direct load of zero did not raise the interrupt");

    a_count_decrement: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        tick && ctrl_reg.counter_width_select && count_reg != 32'h00000000
        |=> count_reg == $past(count_reg) - 32'h00000001) // [RQ3] [RQ18]
        else $error("32-bit count did not drop by one on a tick");

    a_ctrl_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        bus_start && !pwrite_in && paddr_in == ddct_pkg::OFF_TIMER_CONTROL
        |=> prdata_out == {24'h000000, $past(ctrl_reg)}) // [RQ13] [RQ14] [RQ15]
        else $error("control read returned wrong data");

    a_masked_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        bus_start && !pwrite_in && paddr_in == ddct_pkg::OFF_MASKED_STATUS
        |=> prdata_out == {31'h00000000, $past(timer_irq_out)}) // [RQ8] [RQ9]
        else $error("masked status read returned wrong data");

endmodule

/* File: bench/ddct_timer_tb.sv */
module dual_down_counter_timer_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic qual = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timer_irq;
    int bad_count = 0;
    int cmp_count = 0;
    // Behavioural model state.
    logic [7:0] ctrl;
    logic [31:0] reload;
    logic [31:0] cnt;
    logic [31:0] lval;
    logic lpend;
    logic raw;
    int pre;

    always #25 core_clk_in = ~core_clk_in;

    ddct_timer ddct_timer_inst (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .count_clock_qualifier_in(qual),
        .psel_in(psel),
        .penable_in(penable),
        .pwrite_in(pwrite),
        .paddr_in(paddr),
        .pwdata_in(pwdata),
        .prdata_out(prdata),
        .pready_out(pready),
        .pslverr_out(pslverr),
        .timer_irq_out(timer_irq)
    );

    task automatic results();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request is held until the edge that samples pready high; data is taken at that same edge.
    // Right after an edge the design outputs still show what that edge sampled, as they update late.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge core_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
        case (a)
            ddct_pkg::OFF_DIRECT_RELOAD: begin
                reload = d;
                lval = d;
                lpend = 1'b1;
            end
            ddct_pkg::OFF_TIMER_CONTROL: begin
                ctrl = d[7:0];
                if (!d[7]) pre = 0;
            end
            ddct_pkg::OFF_INTERRUPT_CLEAR: raw = 1'b0;
            ddct_pkg::OFF_BACKGROUND_RELOAD: reload = d;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk({31'h0, e}, 32'h0);
    endtask

    function automatic logic is_zero(input logic [31:0] v);
        return ctrl[1] ? (v == 32'h0) : (v[15:0] == 16'h0);
    endfunction

    task automatic edge_m();
        int div;
        div = (ctrl[3:2] == ddct_pkg::PRE_DIV1) ? 1 : (ctrl[3:2] == ddct_pkg::PRE_DIV16) ? 16 : 256;
        if (lpend) begin
            cnt = lval;
            lpend = 1'b0;
            pre = 0;
            if (is_zero(cnt)) raw = 1'b1;
        end else if (ctrl[7]) begin
            pre++;
            if (pre >= div) begin
                pre = 0;
                if (is_zero(cnt)) begin
                    cnt = ctrl[6] ? reload : (ctrl[1] ? 32'hffffffff : {cnt[31:16], 16'hffff});
                end else begin
                    cnt = ctrl[1] ? cnt - 32'h1 : {cnt[31:16], cnt[15:0] - 16'h1};
                end
                if (is_zero(cnt)) raw = 1'b1;
            end
        end
    endtask

    // Qualifier is kept low during bus transfers so that the model order is unambiguous.
    task automatic run_q(input int k);
        logic q;
        logic qp;
        qp = 1'b0;
        repeat (k) begin
            @(posedge core_clk_in);
            if (qp) edge_m();
            q = ($urandom_range(3) != 0);
            qual <= q;
            qp = q;
        end
        @(posedge core_clk_in);
        if (qp) edge_m();
        qual <= 1'b0;
    endtask

    task automatic check_all();
        logic [31:0] r;
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, timer_irq}, {31'h0, raw & ctrl[5]});
        rd(ddct_pkg::OFF_DIRECT_RELOAD, r);
        chk(r, reload);
        rd(ddct_pkg::OFF_BACKGROUND_RELOAD, r);
        chk(r, reload);
        rd(ddct_pkg::OFF_CURRENT_COUNT, r);
        chk(r, lpend ? lval : cnt);
        rd(ddct_pkg::OFF_TIMER_CONTROL, r);
        chk(r & 32'hef, {24'h0, ctrl & 8'hef});
        rd(ddct_pkg::OFF_RAW_STATUS, r);
        chk(r & 32'h1, {31'h0, raw});
        rd(ddct_pkg::OFF_MASKED_STATUS, r);
        chk(r & 32'h1, {31'h0, raw & ctrl[5]});
    endtask

    task automatic do_reset();
        sys_rst_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        ctrl = 8'h20;
        reload = 32'h0;
        cnt = 32'hffffffff;
        lpend = 1'b0;
        raw = 1'b0;
        pre = 0;
    endtask

    initial begin
        repeat (90000) @(posedge core_clk_in);
        bad_count++;
        results();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] v;
        logic [7:0] c;
        logic e;
        r = $urandom(32'h79d9310f);
        do_reset();
        check_all();
        apb(1'b1, 12'h01c, $urandom, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'hffc, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        wr(ddct_pkg::OFF_CURRENT_COUNT, $urandom);
        wr(ddct_pkg::OFF_RAW_STATUS, 32'hffffffff);
        wr(ddct_pkg::OFF_DIRECT_RELOAD, 32'h0);
        wr(ddct_pkg::OFF_BACKGROUND_RELOAD, 32'h5);
        run_q(5);
        check_all();
        wr(ddct_pkg::OFF_INTERRUPT_CLEAR, $urandom);
        check_all();
        for (int i = 0; i < 90; i++) begin
            if (i == 45) do_reset();
            v = $urandom_range(40, 1);
            if ($urandom_range(3) == 0) v = v | ($urandom & 32'hffff0000);
            case ($urandom_range(5))
                0: wr(ddct_pkg::OFF_DIRECT_RELOAD, v);
                1: wr(ddct_pkg::OFF_BACKGROUND_RELOAD, v);
                2: begin
                    c = {1'b1, 1'($urandom), 1'($urandom), 1'b0, 2'($urandom_range(2)), 1'($urandom), 1'($urandom)};
                    wr(ddct_pkg::OFF_TIMER_CONTROL, {24'h0, c & 8'h7f});
                    if ($urandom_range(4) != 0) wr(ddct_pkg::OFF_TIMER_CONTROL, {24'h0, c});
                end
                3: wr(ddct_pkg::OFF_INTERRUPT_CLEAR, $urandom);
                default: run_q($urandom_range(300, 1));
            endcase
            check_all();
        end
        results();
    end
endmodule
